//--- hw/sbc_core.sv
// Purpose: byte-level command interpreter of a serial boot loader
// Assumes: one rx byte per rx_valid pulse; flash reads return next cycle
// Notes: password phase is not handled; 10H leads straight to the header
`include "sbc_regs.svh"
module sbc_core
  import sbc_pkg::*;
#(
  parameter int FLASH_BYTES = `SBC_FLASH_BYTES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic mode_det,
  input wire logic mode_clkd,
  input wire logic baud_ok,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic ram_we,
  output logic [31:0] ram_addr,
  output logic [7:0] ram_wdata,
  output logic fl_rd,
  output logic [17:0] fl_addr,
  input wire logic [7:0] fl_rdata,
  output logic jump_valid,
  output logic [31:0] jump_addr,
  output logic jump_isa32
);
  import sbc_pkg::*;

  localparam logic [17:0] SCAN_LAST = 18'(FLASH_BYTES - 1);

  sbc_state_t state_r, ret_r, snd_ret, state_nxt;
  logic snd;
  logic [7:0] snd_data;
  logic mode_clkd_r;
  logic [3:0] cmd_hi_r;
  logic [5:0] idx_r;
  logic [7:0] sum_r;
  logic err_r;
  logic [31:0] start_r, wp_r;
  logic [15:0] cnt_r;
  logic [17:0] scan_r;
  logic [15:0] fsum_r;
  logic fl_vld_r;
  logic rd_req;
  logic [17:0] rd_addr;
  logic rx_bad;
  logic [7:0] rom_byte, info_byte;
  logic sum_clr;
  logic tx_valid_r, ram_we_r, fl_rd_r, jump_valid_r, jump_isa32_r;
  logic [7:0] tx_data_r, ram_wdata_r;
  logic [31:0] ram_addr_r, jump_addr_r;
  logic [17:0] fl_addr_r;

  sbc_info_rom u_rom (
    .idx(6'(idx_r - `SBC_INFO_FLASH)),
    .data(rom_byte)
  );

  // receive errors are meaningless when the controller supplies the clock
  assign rx_bad = rx_err & ~mode_clkd_r;

  always_comb begin
    if (idx_r < `SBC_INFO_FLASH) begin
      info_byte = fl_rdata;
    end else if (idx_r < `SBC_INFO_CKSUM) begin
      info_byte = rom_byte;
    end else begin
      info_byte = 8'h00 - sum_r;
    end
  end

  always_comb begin
    snd = 1'b0;
    snd_data = 8'h00;
    snd_ret = S_CMD;
    state_nxt = state_r;
    rd_req = 1'b0;
    rd_addr = 18'h00000;
    unique case (state_r)
      S_MODE: begin
        if (mode_det) begin
          if (!mode_clkd && !baud_ok) begin
            state_nxt = S_HALT;
          end else begin
            snd = 1'b1;
            snd_data = mode_clkd ? `SBC_ACK_CLKD : `SBC_ACK_UART;
          end
        end
      end
      S_HALT, S_SEND: state_nxt = state_r;
      S_CMD: begin
        if (rx_valid) begin
          snd = 1'b1;
          if (rx_bad) begin
            snd_data = {cmd_hi_r, `SBC_ACK_RXERR};
          end else begin
            snd_data = rx_data;
            unique case (rx_data)
              `SBC_CMD_RAM: snd_ret = S_HDR;
              `SBC_CMD_SUM: snd_ret = S_SUM;
              `SBC_CMD_INFO: snd_ret = S_INFO;
              default: snd_data = {cmd_hi_r, `SBC_ACK_ERR};
            endcase
          end
        end
      end
      S_HDR: begin
        if (rx_valid && idx_r == `SBC_HDR_LAST) begin
          snd = 1'b1;
          if (err_r || rx_bad) begin
            snd_data = {cmd_hi_r, `SBC_ACK_RXERR};
          end else if (8'(sum_r + rx_data) != 8'h00) begin
            snd_data = {cmd_hi_r, `SBC_ACK_ERR};
          end else begin
            snd_data = {cmd_hi_r, `SBC_ACK_OK};
            snd_ret = (cnt_r == 16'h0000) ? S_DCHK : S_DATA;
          end
        end
      end
      S_DATA: begin
        if (rx_valid && cnt_r == 16'h0001) begin
          state_nxt = S_DCHK;
        end
      end
      S_DCHK: begin
        if (rx_valid) begin
          snd = 1'b1;
          if (err_r || rx_bad) begin
            snd_data = {cmd_hi_r, `SBC_ACK_RXERR};
          end else if (8'(sum_r + rx_data) != 8'h00) begin
            snd_data = {cmd_hi_r, `SBC_ACK_ERR};
          end else begin
            snd_data = {cmd_hi_r, `SBC_ACK_OK};
            snd_ret = S_JUMP;
          end
        end
      end
      S_JUMP: state_nxt = S_HALT;
      S_SUM: begin
        rd_req = 1'b1;
        rd_addr = scan_r;
        if (scan_r == SCAN_LAST) begin
          state_nxt = S_SUMW;
        end
      end
      S_SUMW: begin
        // wait for the last flash byte to land in the total
        if (!fl_rd_r && !fl_vld_r) begin
          snd = 1'b1;
          snd_data = fsum_r[15:8];
          snd_ret = S_SUMLO;
        end
      end
      S_SUMLO: begin
        snd = 1'b1;
        snd_data = fsum_r[7:0];
        snd_ret = S_SUMCK;
      end
      S_SUMCK: begin
        // controller checksum is consumed; the next byte is a command
        if (rx_valid) begin
          state_nxt = S_CMD;
        end
      end
      S_INFO: begin
        rd_req = 1'b1;
        rd_addr = `SBC_INFO_BASE + {12'h000, idx_r};
        state_nxt = S_INFOW;
      end
      S_INFOW: begin
        if (fl_vld_r) begin
          snd = 1'b1;
          snd_data = info_byte;
          snd_ret = (idx_r == `SBC_INFO_CKSUM) ? S_CMD : S_INFO;
        end
      end
      default: state_nxt = S_HALT;
    endcase
  end

  assign sum_clr = snd && (snd_ret == S_HDR || snd_ret == S_DATA ||
    snd_ret == S_DCHK || snd_ret == S_INFO) && state_r != S_INFOW;

  // sequencer and transmit holding register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_MODE;
      ret_r <= S_CMD;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
    end else if (state_r == S_SEND) begin
      if (tx_ready) begin
        tx_valid_r <= 1'b0;
        state_r <= ret_r;
      end
    end else if (snd) begin
      tx_valid_r <= 1'b1;
      tx_data_r <= snd_data;
      ret_r <= snd_ret;
      state_r <= S_SEND;
    end else begin
      state_r <= state_nxt;
    end
  end

  // mode and command nibble kept for later acknowledges
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_clkd_r <= 1'b0;
      cmd_hi_r <= `SBC_CMD_HI_RST;
    end else begin
      if (state_r == S_MODE && mode_det) begin
        mode_clkd_r <= mode_clkd;
      end
      if (state_r == S_CMD && rx_valid && !rx_bad && snd_ret != S_CMD) begin
        cmd_hi_r <= rx_data[7:4];
      end
    end
  end

  // byte index, running checksum and receive error accumulation
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_r <= 6'h00;
      sum_r <= 8'h00;
      err_r <= 1'b0;
    end else if (sum_clr) begin
      idx_r <= 6'h00;
      sum_r <= 8'h00;
      err_r <= 1'b0;
    end else if ((state_r == S_HDR || state_r == S_DATA) && rx_valid) begin
      idx_r <= idx_r + 6'h01;
      sum_r <= sum_r + rx_data;
      err_r <= err_r | rx_bad;
    end else if (state_r == S_INFOW && snd) begin
      idx_r <= idx_r + 6'h01;
      sum_r <= sum_r + info_byte;
    end
  end

  // header fields, high byte first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_r <= 32'h00000000;
      wp_r <= 32'h00000000;
      cnt_r <= 16'h0000;
    end else if (state_r == S_HDR && rx_valid) begin
      if (idx_r < 6'h04) begin
        start_r <= {start_r[23:0], rx_data};
        wp_r <= {wp_r[23:0], rx_data};
      end else if (idx_r < `SBC_HDR_LAST) begin
        cnt_r <= {cnt_r[7:0], rx_data};
      end
    end else if (state_r == S_DATA && rx_valid) begin
      wp_r <= wp_r + 32'h00000001;
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // payload store port; the load range is the controller's concern
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ram_we_r <= 1'b0;
      ram_addr_r <= 32'h00000000;
      ram_wdata_r <= 8'h00;
    end else begin
      ram_we_r <= state_r == S_DATA && rx_valid;
      if (state_r == S_DATA && rx_valid) begin
        ram_addr_r <= wp_r;
        ram_wdata_r <= rx_data;
      end
    end
  end

  // flash read port and 16-bit flash total
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fl_rd_r <= 1'b0;
      fl_addr_r <= 18'h00000;
      fl_vld_r <= 1'b0;
      scan_r <= 18'h00000;
      fsum_r <= 16'h0000;
    end else begin
      fl_rd_r <= rd_req;
      fl_addr_r <= rd_addr;
      fl_vld_r <= fl_rd_r;
      if (snd && snd_ret == S_SUM) begin
        scan_r <= 18'h00000;
        fsum_r <= 16'h0000;
      end else begin
        if (state_r == S_SUM) begin
          scan_r <= scan_r + 18'h00001;
        end
        if (fl_vld_r && (state_r == S_SUM || state_r == S_SUMW)) begin
          fsum_r <= fsum_r + {8'h00, fl_rdata};
        end
      end
    end
  end

  // hand-off to loaded code, entered only after a good payload ack
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      jump_valid_r <= 1'b0;
      jump_addr_r <= 32'h00000000;
      jump_isa32_r <= 1'b0;
    end else begin
      jump_valid_r <= state_r == S_JUMP;
      if (state_r == S_JUMP) begin
        jump_addr_r <= start_r;
        jump_isa32_r <= 1'b1;
      end
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign ram_we = ram_we_r;
  assign ram_addr = ram_addr_r;
  assign ram_wdata = ram_wdata_r;
  assign fl_rd = fl_rd_r;
  assign fl_addr = fl_addr_r;
  assign jump_valid = jump_valid_r;
  assign jump_addr = jump_addr_r;
  assign jump_isa32 = jump_isa32_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_ack(logic [3:0] lo);
    tx_valid_r && state_r == S_SEND && tx_data_r[3:0] == lo;
  endsequence

  sequence s_hdr_last;
    state_r == S_HDR && rx_valid && idx_r == `SBC_HDR_LAST &&
      !err_r && !rx_bad;
  endsequence

  property p_hdr_bad;
    s_hdr_last and (8'(sum_r + rx_data) != 8'h00) |=>
      s_ack(`SBC_ACK_ERR) ##0 ret_r == S_CMD;
  endproperty
  a_hdr_bad: assert property (p_hdr_bad)
    else $error("bad header sum not answered with error");

  property p_hdr_ok;
    s_hdr_last and (8'(sum_r + rx_data) == 8'h00) |=>
      s_ack(`SBC_ACK_OK) ##0 ret_r != S_CMD;
  endproperty
  a_hdr_ok: assert property (p_hdr_ok)
    else $error("good header not acknowledged");

  property p_store;
    state_r == S_DATA && rx_valid |=>
      ram_we_r && ram_wdata_r == $past(rx_data) &&
      ram_addr_r == $past(wp_r);
  endproperty
  a_store: assert property (p_store)
    else $error("payload byte not stored");

  property p_data_err;
    state_r == S_DCHK && rx_valid && (err_r || rx_bad) |=>
      tx_data_r == {$past(cmd_hi_r), `SBC_ACK_RXERR} && ret_r == S_CMD;
  endproperty
  a_data_err: assert property (p_data_err)
    else $error("payload receive error not reported");

  property p_data_ok;
    state_r == S_DCHK && rx_valid && !err_r && !rx_bad &&
      8'(sum_r + rx_data) == 8'h00 |=> s_ack(`SBC_ACK_OK) ##0
      ret_r == S_JUMP;
  endproperty
  a_data_ok: assert property (p_data_ok)
    else $error("good payload not acknowledged");

  property p_jump;
    state_r == S_JUMP |=> jump_valid_r && jump_isa32_r &&
      jump_addr_r == $past(start_r) ##1 !jump_valid_r;
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump not issued to start address");

  property p_sum_hi;
    state_r == S_SUMW && snd |=> tx_data_r == $past(fsum_r[15:8]);
  endproperty
  a_sum_hi: assert property (p_sum_hi)
    else $error("flash total high byte not sent first");

  property p_echo;
    state_r == S_CMD && rx_valid && !rx_bad &&
      (rx_data == `SBC_CMD_SUM || rx_data == `SBC_CMD_INFO) |=>
      tx_data_r == $past(rx_data);
  endproperty
  a_echo: assert property (p_echo)
    else $error("valid command not echoed");

  property p_halt;
    state_r == S_MODE && mode_det && !mode_clkd && !baud_ok |=>
      (state_r == S_HALT && !tx_valid_r) [*3];
  endproperty
  a_halt: assert property (p_halt)
    else $error("unusable baud rate did not halt silently");

  property p_ack_bits;
    state_r == S_SEND && ret_r == S_CMD && state_r != $past(state_r) &&
      $past(state_r) != S_MODE && $past(state_r) != S_INFOW |->
      tx_data_r[2:1] == 2'b00;
  endproperty
  a_ack_bits: assert property (p_ack_bits)
    else $error("acknowledge bits 1 and 2 not zero");
endmodule

//--- hw/sbc_regs.svh
// Purpose: constants of the serial boot command handler
// Assumes: byte-wide receive and transmit streams
// Notes: acknowledge low nibbles combine with the last accepted command's upper nibble
`ifndef SBC_REGS_SVH
`define SBC_REGS_SVH

`define SBC_ACK_UART 8'h86
`define SBC_ACK_CLKD 8'h30
`define SBC_CMD_RAM 8'h10
`define SBC_CMD_SUM 8'h20
`define SBC_CMD_INFO 8'h30
`define SBC_ACK_OK 4'h0
`define SBC_ACK_ERR 4'h1
`define SBC_ACK_RXERR 4'h8
`define SBC_CMD_HI_RST 4'h0
`define SBC_HDR_LAST 6'h06
`define SBC_INFO_FLASH 6'h04
`define SBC_INFO_CKSUM 6'h3D
`define SBC_INFO_BASE 18'h00470
`define SBC_FLASH_BYTES 262144
`define SBC_INFO_ROM_LEN 57

`endif

//--- hw/sbc_pkg.sv
// Purpose: types of the serial boot command handler
// Assumes: nothing beyond the shared constants header
// Notes: state names follow the byte sequence of each command
package sbc_pkg;
  typedef enum logic [3:0] {
    S_MODE, S_HALT, S_CMD, S_SEND, S_HDR, S_DATA, S_DCHK, S_JUMP,
    S_SUM, S_SUMW, S_SUMLO, S_SUMCK, S_INFO, S_INFOW
  } sbc_state_t;
endpackage

//--- hw/sbc_info_rom.sv
// Purpose: fixed bytes of the product information reply
// Assumes: index 0 is the first name byte
// Notes: multi-byte fields are stored least significant byte first
`include "sbc_regs.svh"
module sbc_info_rom #(
  // arbitrary neutral product name, nine ASCII characters
  parameter logic [71:0] PROD_NAME = "BOOTDEV01"
) (
  input wire logic [5:0] idx,
  output logic [7:0] data
);
  always_comb begin
    data = 8'h00;
    if (idx < 6'h09) begin
      data = PROD_NAME[8'(71 - 8 * idx) -: 8];
    end else begin
      unique case (idx)
        6'h09, 6'h0A, 6'h0B: data = 8'h20;
        6'h0C: data = 8'h74;
        6'h0D: data = 8'h04;
        6'h11: data = 8'h98;
        6'h12, 6'h13, 6'h14: data = 8'hFF;
        6'h15: data = 8'hA7;
        6'h16, 6'h17, 6'h18, 6'h19: data = 8'hFF;
        6'h1A: data = 8'hBF;
        6'h1B: data = 8'hFF;
        6'h1D: data = 8'hA8;
        6'h1E, 6'h1F, 6'h20: data = 8'hFF;
        6'h21: data = 8'hAF;
        6'h22, 6'h23: data = 8'hFF;
        6'h2A, 6'h2B: data = 8'hFF;
        6'h2C: data = 8'h03;
        6'h2E: data = 8'h02;
        // one group: two 128-Kbyte blocks of 64K half-words
        6'h36: data = 8'h01;
        6'h38: data = 8'h02;
        default: data = 8'h00;
      endcase
    end
  end
endmodule

//--- bench/sbc_ctl_model.sv
// Purpose: behavioural model of the external programming controller
// Assumes: one byte in flight, each ack accepted before the next byte
// Notes: stall_cyc holds tx_ready back to act as a slow controller
module sbc_ctl_model (
  input wire logic sys_clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_err,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  int stall_cyc = 0;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_err = 1'b0;
    tx_ready = 1'b0;
  end

  // idle line shows the inverse of the last byte, never a stale copy
  task automatic send(input logic [7:0] b, input logic e);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_err <= e;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    rx_err <= ~e;
  endtask

  // fix is added to the checksum byte to corrupt it on purpose
  task automatic send_chk(input logic [7:0] q[$], input logic [7:0] fix,
                          input int err_at);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    q.push_back(8'h00 - s + fix);
    foreach (q[i]) send(q[i], i == err_at);
  endtask

  task automatic send_hdr(input logic [31:0] a, input logic [15:0] n,
                          input logic [7:0] fix, input int err_at);
    logic [7:0] q[$];
    q = '{a[31:24], a[23:16], a[15:8], a[7:0], n[15:8], n[7:0]};
    send_chk(q, fix, err_at);
  endtask

  task automatic get(output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge sys_clk);
      ok = (tx_valid === 1'b1);
    end
    if (ok) begin
      repeat (stall_cyc) @(posedge sys_clk);
      tx_ready <= 1'b1;
      @(posedge sys_clk);
      d = tx_data;
      tx_ready <= 1'b0;
    end
  endtask
endmodule

//--- bench/test_serial_boot_command_handler.sv
// Purpose: self-checking bench of the serial boot command handler
// Assumes: flash model answers one cycle after a read request
// Notes: a small flash keeps the sum scan short
`include "sbc_regs.svh"
module test_serial_boot_command_handler;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] START = 32'hFFFF_9800;
  localparam logic [71:0] NAME = "BOOTDEV01";
  localparam logic [7:0] FIXB [45] = '{
    8'h74, 8'h04, 8'h00, 8'h00, 8'h00, 8'h98, 8'hFF, 8'hFF, 8'hFF, 8'hA7,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'h00, 8'hA8, 8'hFF, 8'hFF,
    8'hFF, 8'hAF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'hFF, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h02};

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic mode_det = 1'b0;
  logic mode_clkd = 1'b0;
  logic baud_ok = 1'b1;
  logic rx_valid, rx_err, tx_ready, tx_valid, ram_we, fl_rd;
  logic jump_valid, jump_isa32;
  logic [7:0] rx_data, tx_data, ram_wdata;
  logic [7:0] fl_rdata = 8'h00;
  logic [31:0] ram_addr, jump_addr, jump_a;
  logic [17:0] fl_addr;
  logic jump_m;
  int jump_n = 0;
  int err_count = 0;
  int total_checks = 0;
  logic [39:0] wr_q[$];
  logic [7:0] pay[$] = '{8'hAA, 8'h55, 8'h0F};
  logic [7:0] iexp [62];
  logic [7:0] s, d;
  logic [15:0] fsum;
  bit ok;
  logic [16:0] rows [4] = '{{8'h55, 1'b0, 8'h01}, {8'h10, 1'b1, 8'h08},
                            {8'hFF, 1'b0, 8'h01}, {8'h00, 1'b0, 8'h01}};

  always #4 sys_clk = ~sys_clk;

  sbc_core #(.FLASH_BYTES(16)) DUT (
    .sys_clk(sys_clk), .rstn(rstn), .mode_det(mode_det),
    .mode_clkd(mode_clkd), .baud_ok(baud_ok), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .fl_rd(fl_rd),
    .fl_addr(fl_addr), .fl_rdata(fl_rdata), .jump_valid(jump_valid),
    .jump_addr(jump_addr), .jump_isa32(jump_isa32)
  );

  sbc_ctl_model ctl (
    .sys_clk(sys_clk), .tx_valid(tx_valid), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
    .tx_ready(tx_ready)
  );

  function automatic logic [7:0] fmem(input logic [17:0] a);
    return a[7:0] ^ 8'h3C;
  endfunction

  // data line churns between reads so a late sample cannot pass
  always @(posedge sys_clk) fl_rdata <= fl_rd ? fmem(fl_addr) : ~fl_rdata;

  always @(posedge sys_clk) begin
    if (ram_we === 1'b1) wr_q.push_back({ram_addr, ram_wdata});
    if (jump_valid === 1'b1) begin
      jump_n++;
      jump_a = jump_addr;
      jump_m = jump_isa32;
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ack(input string nm, input logic [7:0] e);
    ctl.get(d, ok);
    chk(nm, e, ok ? d : 8'hXX);
  endtask

  task automatic cmd(input logic [7:0] b, input logic e, input logic [7:0] x);
    ctl.send(b, e);
    ack("cmd_ack", x);
  endtask

  task automatic do_reset(input logic clkd, input logic bok);
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("rst_out", 32'h0, {tx_valid, ram_we, fl_rd, jump_valid, jump_isa32});
    rstn <= 1'b1;
    @(posedge sys_clk);
    mode_det <= 1'b1;
    mode_clkd <= clkd;
    baud_ok <= bok;
    @(posedge sys_clk);
    mode_det <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end

  initial begin
    fsum = 16'h0000;
    for (int i = 0; i < 16; i++) fsum = fsum + fmem(i);
    for (int i = 0; i < 4; i++) iexp[i] = fmem(18'h00470 + i);
    for (int i = 0; i < 9; i++) iexp[4 + i] = NAME[71 - 8 * i -: 8];
    for (int i = 13; i < 16; i++) iexp[i] = 8'h20;
    foreach (FIXB[i]) iexp[16 + i] = FIXB[i];
    s = 8'h00;
    for (int i = 0; i < 61; i++) s = s + iexp[i];
    iexp[61] = 8'h00 - s;

    do_reset(1'b0, 1'b1);
    ack("mode_uart", `SBC_ACK_UART);
    foreach (rows[i]) cmd(rows[i][16:9], rows[i][8], rows[i][7:0]);
    $display("test command table done");

    cmd(`SBC_CMD_SUM, 1'b0, 8'h20);
    ack("sum_hi", fsum[15:8]);
    ack("sum_lo", fsum[7:0]);
    ctl.send(8'h00 - fsum[15:8] - fsum[7:0], 1'b0);
    cmd(8'h7E, 1'b0, 8'h21);
    cmd(8'h20, 1'b1, 8'h28);
    $display("test flash sum done");

    ctl.stall_cyc = 2;
    cmd(`SBC_CMD_INFO, 1'b0, 8'h30);
    for (int i = 0; i < 61; i++) begin
      ack("info", iexp[i]);
    end
    ack("info_ck", iexp[61]);
    ctl.stall_cyc = 0;
    cmd(8'h30, 1'b1, 8'h38);
    $display("test product info done");

    cmd(`SBC_CMD_RAM, 1'b0, 8'h10);
    ctl.send_hdr(START, 16'h0003, 8'h01, -1);
    ack("hdr_bad", 8'h11);
    cmd(`SBC_CMD_RAM, 1'b0, 8'h10);
    ctl.send_hdr(START, 16'h0003, 8'h00, 2);
    ack("hdr_rxerr", 8'h18);
    cmd(`SBC_CMD_RAM, 1'b0, 8'h10);
    ctl.send_hdr(START, 16'h0003, 8'h00, -1);
    ack("hdr_ok", 8'h10);
    ctl.send_chk(pay, 8'h00, 1);
    ack("pay_rxerr", 8'h18);
    cmd(`SBC_CMD_RAM, 1'b0, 8'h10);
    ctl.send_hdr(START, 16'h0003, 8'h00, -1);
    ack("hdr_ok", 8'h10);
    ctl.send_chk(pay, 8'h01, -1);
    ack("pay_bad", 8'h11);
    wr_q.delete();
    cmd(`SBC_CMD_RAM, 1'b0, 8'h10);
    ctl.send_hdr(START, 16'h0003, 8'h00, -1);
    ack("hdr_ok", 8'h10);
    ctl.send_chk(pay, 8'h00, -1);
    ack("pay_ok", 8'h10);
    repeat (4) @(posedge sys_clk);
    chk("wr_count", 3, wr_q.size());
    for (int i = 0; i < 3; i++) begin
      chk("wr_addr", START + i, wr_q[i][39:8]);
      chk("wr_data", pay[i], wr_q[i][7:0]);
    end
    chk("jump_count", 1, jump_n);
    chk("jump_addr", START, jump_a);
    chk("jump_isa32", 1, jump_m);
    ctl.send(`SBC_CMD_SUM, 1'b0);
    ctl.get(d, ok);
    chk("after_jump", 0, ok);
    $display("test ram load done");

    do_reset(1'b1, 1'b1);
    ack("mode_clkd", `SBC_ACK_CLKD);
    cmd(8'h55, 1'b1, 8'h01);
    $display("test clocked mode done");

    do_reset(1'b0, 1'b0);
    ctl.get(d, ok);
    chk("halt_silent", 0, ok);
    ctl.send(`SBC_CMD_SUM, 1'b0);
    ctl.get(d, ok);
    chk("halt_cmd", 0, ok);
    $display("test baud halt done");
    end_of_test();
  end
endmodule
